//--- design/qhp_pkg.sv
// Shared constants and types of the quad transceiver host port
package qhp_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int QHP_NCH       = 4;
  localparam int QHP_AW        = 6;
  localparam int QHP_CMD_BITS  = 8;
  localparam int QHP_SYS_NS    = 40;
  localparam int QHP_SCLK_NS   = 640;
  localparam int QHP_QTR_CYC   = QHP_SCLK_NS / 4 / QHP_SYS_NS;
  localparam int QHP_STEP_NS   = 320;
  localparam int QHP_STEP_CYC  = QHP_STEP_NS / QHP_SYS_NS;
  localparam int QHP_PAR_LAST  = 3;
  localparam int QHP_SER_LAST  = 63;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [5:0] QHP_ADDR_SR1  = 6'h0A;
  localparam logic [5:0] QHP_ADDR_SR2  = 6'h0B;
  localparam logic [5:0] QHP_ADDR_LSR  = 6'h1C;
  localparam logic [5:0] QHP_ADDR_MSK1 = 6'h1D;
  localparam logic [5:0] QHP_ADDR_MSK2 = 6'h1E;
  localparam logic [5:0] QHP_ADDR_MSKL = 6'h1F;
  localparam logic [7:0] QHP_REG_RST   = 8'h00;

  // Pin order: cs, pick1, pick0, type hi, type lo, style, in_edge_sel, out_edge_sel, ale, rd, wr, addr, bus
  localparam logic [23:0] QHP_PIN_INIT  = 24'h8060FF;
  localparam logic [8:0]  QHP_HOST_INIT = 9'h1FF;

  typedef enum logic [1:0] {QHP_MUX, QHP_NONMUX, QHP_SERIAL, QHP_TEST} qhp_mode_t;
  typedef enum logic [1:0] {QHP_H_IDLE, QHP_H_PAR, QHP_H_SER, QHP_H_DONE} qhp_hstate_t;

endpackage : qhp_pkg

//--- design/qhp_if.sv
// Pin bundle between host and transceiver port, with wire resolution
interface qhp_if;
  logic       cs_n;
  logic       channel_pick_0;
  logic       channel_pick_1;
  logic       port_type_sel_lo;
  logic       port_type_sel_hi;
  logic       parallel_style_sel;
  logic       in_edge_sel;
  logic       out_edge_sel;
  logic [4:0] low_addr_lines;
  logic       addr_latch_or_top_addr;
  logic       read_strobe_or_serial_clk;
  logic       write_strobe_or_serial_in;
  logic [7:0] host_bus_out;
  logic       host_bus_oe;
  logic [7:0] dev_bus_out;
  logic [7:0] dev_bus_oe;
  logic       int_out;
  logic       int_oe;
  logic [7:0] shared_bus_lines;
  logic       int_n;

  // Undriven lines float high through the board pull-ups
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      shared_bus_lines[i] = dev_bus_oe[i] ? dev_bus_out[i] :
                            host_bus_oe ? host_bus_out[i] : 1'b1;
    end
  end
  assign int_n = int_oe ? int_out : 1'b1;

  modport dev (
    input  cs_n, channel_pick_0, channel_pick_1, port_type_sel_lo, port_type_sel_hi,
    input  parallel_style_sel, in_edge_sel, out_edge_sel, low_addr_lines,
    input  addr_latch_or_top_addr, read_strobe_or_serial_clk, write_strobe_or_serial_in,
    input  shared_bus_lines,
    output dev_bus_out, dev_bus_oe, int_out, int_oe
  );
  modport host (
    output cs_n, channel_pick_0, channel_pick_1, port_type_sel_lo, port_type_sel_hi,
    output parallel_style_sel, in_edge_sel, out_edge_sel, low_addr_lines,
    output addr_latch_or_top_addr, read_strobe_or_serial_clk, write_strobe_or_serial_in,
    output host_bus_out, host_bus_oe,
    input  shared_bus_lines, int_n
  );
endinterface : qhp_if

//--- design/qhp_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain
module qhp_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : qhp_sync

//--- design/qhp_dev_end.sv
// Transceiver end of the host port: parallel and serial access to four register sets

module qhp_dev_end
  import qhp_pkg::*;
#(
  parameter int NCH = QHP_NCH
)(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  qhp_if.dev                     port,
  input  wire logic [NCH*24-1:0] status_cond,
  output logic                   cfg_wr_valid,
  output logic [1:0]             cfg_wr_chan,
  output logic [5:0]             cfg_wr_addr,
  output logic [7:0]             cfg_wr_data
);

  if (NCH != 4)
  begin : g_bad_nch
    $error("qhp_dev_end: two select pins serve exactly four channels");
  end

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [23:0] pins_raw;
  logic [23:0] pins_s;
  logic        cs_n_s;
  logic [1:0]  chan;
  qhp_mode_t   mode;
  logic        style_s;
  logic        in_edge_sel_s;
  logic        out_edge_sel_s;
  logic        ale_s;
  logic        rd_s;
  logic        wr_s;
  logic [4:0]  laddr_s;
  logic [7:0]  bus_s;

  assign pins_raw = {port.cs_n, port.channel_pick_1, port.channel_pick_0,
                     port.port_type_sel_hi, port.port_type_sel_lo, port.parallel_style_sel,
                     port.in_edge_sel, port.out_edge_sel, port.addr_latch_or_top_addr,
                     port.read_strobe_or_serial_clk, port.write_strobe_or_serial_in,
                     port.low_addr_lines, port.shared_bus_lines};

  qhp_sync #(.W(24), .INIT(QHP_PIN_INIT)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  assign cs_n_s  = pins_s[23];
  assign chan    = pins_s[22:21];
  assign mode    = qhp_mode_t'(pins_s[20:19]);
  assign style_s = pins_s[18];
  assign in_edge_sel_s  = pins_s[17];
  assign out_edge_sel_s  = pins_s[16];
  assign ale_s   = pins_s[15];
  assign rd_s    = pins_s[14];
  assign wr_s    = pins_s[13];
  assign laddr_s = pins_s[12:8];
  assign bus_s   = pins_s[7:0];

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]        regs [NCH*64];
  logic [7:0]        sticky [NCH*3];
  logic [NCH*24-1:0] cond_q;

  function automatic logic [5:0] st_addr(input int k);
    return (k == 0) ? QHP_ADDR_SR1 : (k == 1) ? QHP_ADDR_SR2 : QHP_ADDR_LSR;
  endfunction : st_addr

  function automatic logic [5:0] mask_addr(input int k);
    return (k == 0) ? QHP_ADDR_MSK1 : (k == 1) ? QHP_ADDR_MSK2 : QHP_ADDR_MSKL;
  endfunction : mask_addr

  function automatic logic [7:0] rd_byte(input logic [1:0] ch, input logic [5:0] a);
    logic [7:0] v;
    v = regs[{ch, a}];
    for (int k = 0; k < 3; k++)
    begin
      if (a == st_addr(k))
        v = sticky[int'(ch) * 3 + k];
    end
    return v;
  endfunction : rd_byte

  // ****************************************************************
  // Parallel port decode
  // ****************************************************************
  logic       sel;
  logic       par_on;
  logic       is_mux;
  logic       ds_act;
  logic       p_rd;
  logic       p_wr;
  logic       p_wr_q;
  logic       ale_q;
  logic [5:0] maddr;
  logic [5:0] p_addr;
  logic [7:0] pwdata;
  logic       p_commit;

  assign sel    = !cs_n_s;
  assign is_mux = (mode == QHP_MUX);
  assign par_on = sel && (mode == QHP_MUX || mode == QHP_NONMUX);
  // Data strobe polarity flips on the multiplexed bus
  assign ds_act = is_mux ? rd_s : !rd_s;
  assign p_rd   = style_s ? (ds_act && wr_s) : !rd_s;
  assign p_wr   = style_s ? (ds_act && !wr_s) : !wr_s;
  assign p_addr = is_mux ? maddr : {ale_s, laddr_s};
  // Write lands when the strobe closes, so data has settled all through it
  assign p_commit = par_on && p_wr_q && !p_wr;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ale_q  <= 1'b0;
      p_wr_q <= 1'b0;
      maddr  <= '0;
      pwdata <= QHP_REG_RST;
    end
    else
    begin
      ale_q  <= ale_s;
      p_wr_q <= p_wr && par_on;
      if (par_on && is_mux && !ale_q && ale_s)
        maddr <= bus_s[5:0];
      if (p_wr)
        pwdata <= bus_s;
    end
  end

  // ****************************************************************
  // Serial port
  // ****************************************************************
  logic       ser_on;
  logic       sclk_q;
  logic       in_edge;
  logic       out_edge;
  logic [9:0] icnt;
  logic [9:0] ocnt;
  logic [9:0] obase;
  logic [9:0] oidx;
  logic [7:0] cmd;
  logic [7:0] dbyte;
  logic       s_wr;
  logic [4:0] s_waddr;
  logic       s_rd_ok;
  logic [7:0] s_rbyte;
  logic [7:0] p_rbyte;

  assign ser_on   = sel && (mode == QHP_SERIAL);
  // Serial clock edges come only from the host pin
  assign in_edge  = in_edge_sel_s ? (sclk_q && !rd_s) : (!sclk_q && rd_s);
  assign out_edge = out_edge_sel_s ? (!sclk_q && rd_s) : (sclk_q && !rd_s);
  assign obase    = out_edge_sel_s ? 10'h008 : 10'h007;
  assign oidx     = ocnt - obase;
  assign s_waddr  = cmd[5:1] + 5'(icnt[7:3] - 5'h01);
  // Burst bit off limits the transfer to one data byte
  assign s_wr     = ser_on && in_edge && icnt >= 10'h008 && icnt[2:0] == 3'h7
                    && !cmd[0] && (cmd[7] || icnt < 10'h010) && icnt != 10'h3FF;
  assign s_rd_ok  = ser_on && out_edge && cmd[0] && ocnt >= obase
                    && (cmd[7] || oidx < 10'h008);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // Match the pin's reset level so no false clock edge follows reset
      sclk_q <= QHP_PIN_INIT[14];
      icnt   <= '0;
      ocnt   <= '0;
      cmd    <= '0;
      dbyte  <= '0;
    end
    else
    begin
      sclk_q <= rd_s;
      if (!ser_on)
      begin
        icnt  <= '0;
        ocnt  <= '0;
        cmd   <= '0;
        dbyte <= '0;
      end
      else
      begin
        if (in_edge)
        begin
          // Least significant bit arrives first
          if (icnt < 10'h008)
            cmd[icnt[2:0]] <= wr_s;
          else
            dbyte[icnt[2:0]] <= wr_s;
          if (icnt != 10'h3FF)
            icnt <= icnt + 10'h001;
        end
        if (out_edge && ocnt != 10'h3FF)
          ocnt <= ocnt + 10'h001;
      end
    end
  end

  always_comb
  begin
    p_rbyte = rd_byte(chan, p_addr);
    s_rbyte = rd_byte(chan, {1'b0, 5'(cmd[5:1] + oidx[7:3])});
  end

  // ****************************************************************
  // Register write port and status
  // ****************************************************************
  logic       w_en;
  logic [5:0] w_addr;
  logic [7:0] w_data;

  assign w_en   = p_commit || s_wr;
  assign w_addr = s_wr ? {1'b0, s_waddr} : p_addr;
  assign w_data = s_wr ? {wr_s, dbyte[6:0]} : pwdata;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NCH*64; i++)
        regs[i] <= QHP_REG_RST;
    end
    else if (w_en)
    begin
      regs[{chan, w_addr}] <= w_data;
    end
  end

  // Sticky bits catch every change; a change in the clearing cycle survives
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cond_q <= '0;
      for (int i = 0; i < NCH*3; i++)
        sticky[i] <= QHP_REG_RST;
    end
    else
    begin
      cond_q <= status_cond;
      for (int i = 0; i < NCH*3; i++)
      begin
        sticky[i] <= (sticky[i] & ~((w_en && chan == 2'(i / 3) && w_addr == st_addr(i % 3))
                                    ? w_data : 8'h00))
                     | (status_cond[i*8 +: 8] ^ cond_q[i*8 +: 8]);
      end
    end
  end

  logic irq_any;

  always_comb
  begin
    irq_any = 1'b0;
    for (int i = 0; i < NCH*3; i++)
    begin
      irq_any = irq_any | (|((sticky[i] | status_cond[i*8 +: 8])
                             & regs[{2'(i / 3), mask_addr(i % 3)}]));
    end
  end

  // ****************************************************************
  // Pin drivers and user side
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port.dev_bus_out <= 8'hFF;
      port.dev_bus_oe  <= 8'h00;
      port.int_out     <= 1'b0;
      port.int_oe      <= 1'b0;
    end
    else
    begin
      port.int_out <= 1'b0;
      port.int_oe  <= irq_any && mode != QHP_TEST;
      if (ser_on)
      begin
        port.dev_bus_oe <= 8'h80;
        if (s_rd_ok)
          port.dev_bus_out[7] <= s_rbyte[oidx[2:0]];
      end
      else
      begin
        port.dev_bus_oe  <= (par_on && p_rd) ? 8'hFF : 8'h00;
        port.dev_bus_out <= p_rbyte;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_wr_valid <= 1'b0;
      cfg_wr_chan  <= '0;
      cfg_wr_addr  <= '0;
      cfg_wr_data  <= QHP_REG_RST;
    end
    else
    begin
      cfg_wr_valid <= w_en;
      if (w_en)
      begin
        cfg_wr_chan <= chan;
        cfg_wr_addr <= w_addr;
        cfg_wr_data <= w_data;
      end
    end
  end

endmodule : qhp_dev_end

//--- design/qhp_host_end.sv
// Host end of the port: runs single register reads and writes over the pins
module qhp_host_end
  import qhp_pkg::*;
#(
  parameter int STEP_CYC = QHP_STEP_CYC,
  parameter int QTR_CYC  = QHP_QTR_CYC
)(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  qhp_if.host             port,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_read,
  input  wire logic [1:0] req_chan,
  input  wire logic [5:0] req_addr,
  input  wire logic [7:0] req_wdata,
  input  wire logic [1:0] cfg_port_type,
  input  wire logic       cfg_style,
  input  wire logic       cfg_in_edge,
  input  wire logic       cfg_out_edge,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            irq
);

  if (STEP_CYC < 8 || QTR_CYC < 4)
  begin : g_bad_timing
    $error("qhp_host_end: phases too short for the synchroniser latency");
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  qhp_hstate_t st;
  logic [7:0]  tcnt;
  logic [5:0]  pcnt;
  logic        rd_l;
  logic [5:0]  addr_l;
  logic [7:0]  wdata_l;
  logic [8:0]  sync_s;
  logic        last;
  logic [3:0]  slot;
  logic [1:0]  qtr;
  qhp_mode_t   mode_l;
  logic        mux;
  logic [7:0]  cmd;

  qhp_sync #(.W(9), .INIT(QHP_HOST_INIT)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({port.int_n, port.shared_bus_lines}),
    .dout    (sync_s)
  );

  assign last = (st == QHP_H_SER) ? (tcnt == 8'(QTR_CYC - 1)) : (tcnt == 8'(STEP_CYC - 1));
  assign slot = pcnt[5:2];
  assign qtr  = pcnt[1:0];
  assign mux  = (mode_l == QHP_MUX);
  // Single transfers only: burst and reserved bits stay zero
  assign cmd  = {2'b00, addr_l[4:0], rd_l};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st        <= QHP_H_IDLE;
      tcnt      <= '0;
      pcnt      <= '0;
      req_ready <= 1'b0;
      rd_l      <= 1'b0;
      addr_l    <= '0;
      wdata_l   <= '0;
      mode_l    <= QHP_MUX;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      tcnt      <= last ? 8'h00 : tcnt + 8'h01;
      case (st)
        QHP_H_IDLE:
        begin
          tcnt   <= '0;
          pcnt   <= '0;
          mode_l <= qhp_mode_t'(cfg_port_type);
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            rd_l      <= req_read;
            addr_l    <= req_addr;
            wdata_l   <= req_wdata;
            rsp_rdata <= 8'hFF;
            // Outputs-off mode cannot carry an access; it completes empty
            st <= (mode_l == QHP_SERIAL) ? QHP_H_SER :
                  (mode_l == QHP_TEST) ? QHP_H_DONE : QHP_H_PAR;
          end
          else
            req_ready <= 1'b1;
        end
        QHP_H_PAR:
        begin
          if (last && pcnt == 6'(2) && rd_l)
            rsp_rdata <= sync_s[7:0];
          if (last)
          begin
            pcnt <= pcnt + 6'h01;
            if (pcnt == 6'(QHP_PAR_LAST))
              st <= QHP_H_DONE;
          end
        end
        QHP_H_SER:
        begin
          if (last && rd_l && slot >= 4'h8 && qtr == (cfg_out_edge ? 2'h3 : 2'h2))
            rsp_rdata[slot[2:0]] <= sync_s[7];
          if (last)
          begin
            pcnt <= pcnt + 6'h01;
            if (pcnt == 6'(QHP_SER_LAST))
              st <= QHP_H_DONE;
          end
        end
        QHP_H_DONE:
        begin
          if (last)
          begin
            rsp_valid <= 1'b1;
            st        <= QHP_H_IDLE;
          end
        end
        default:
          st <= QHP_H_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port.cs_n                      <= 1'b1;
      port.channel_pick_0            <= 1'b0;
      port.channel_pick_1            <= 1'b0;
      port.port_type_sel_lo          <= 1'b0;
      port.port_type_sel_hi          <= 1'b0;
      port.parallel_style_sel        <= 1'b0;
      port.in_edge_sel               <= 1'b0;
      port.out_edge_sel              <= 1'b0;
      port.low_addr_lines            <= '0;
      port.addr_latch_or_top_addr    <= 1'b0;
      port.read_strobe_or_serial_clk <= 1'b1;
      port.write_strobe_or_serial_in <= 1'b1;
      port.host_bus_out              <= 8'hFF;
      port.host_bus_oe               <= 1'b0;
      irq                            <= 1'b0;
    end
    else
    begin
      irq <= !sync_s[8];
      port.cs_n <= !(st == QHP_H_PAR || st == QHP_H_SER);
      if (st == QHP_H_IDLE)
      begin
        {port.port_type_sel_hi, port.port_type_sel_lo} <= cfg_port_type;
        port.parallel_style_sel <= cfg_style;
        port.in_edge_sel        <= cfg_in_edge;
        port.out_edge_sel       <= cfg_out_edge;
        {port.channel_pick_1, port.channel_pick_0} <= req_chan;
      end
      case (st)
        QHP_H_PAR:
        begin
          port.low_addr_lines         <= mux ? 5'h00 : addr_l[4:0];
          port.addr_latch_or_top_addr <= mux ? (pcnt == 6'(1)) : addr_l[5];
          port.host_bus_oe  <= mux ? (pcnt < 6'(2) || !rd_l) : !rd_l;
          port.host_bus_out <= (mux && pcnt < 6'(2)) ? {2'b00, addr_l} : wdata_l;
          if (cfg_style)
          begin
            port.read_strobe_or_serial_clk <= mux ? (pcnt == 6'(2)) : (pcnt != 6'(2));
            port.write_strobe_or_serial_in <= rd_l;
          end
          else
          begin
            port.read_strobe_or_serial_clk <= !(pcnt == 6'(2) && rd_l);
            port.write_strobe_or_serial_in <= !(pcnt == 6'(2) && !rd_l);
          end
        end
        QHP_H_SER:
        begin
          port.low_addr_lines            <= 5'h00;
          port.addr_latch_or_top_addr    <= 1'b0;
          port.host_bus_oe               <= 1'b0;
          // Data changes in the low quarter, so both clock edges see it stable
          port.read_strobe_or_serial_clk <= (qtr == 2'h1 || qtr == 2'h2);
          port.write_strobe_or_serial_in <= (slot < 4'h8) ? cmd[slot[2:0]] : wdata_l[slot[2:0]];
        end
        default:
        begin
          port.host_bus_oe               <= 1'b0;
          port.read_strobe_or_serial_clk <= !(mode_l == QHP_SERIAL || (mux && cfg_style));
          port.write_strobe_or_serial_in <= 1'b1;
        end
      endcase
    end
  end

endmodule : qhp_host_end

//--- verification/qhp_asserts.sv
// Pin-level checks of the host port between its two ends
module qhp_asserts (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       port_type_sel_hi,
  input wire logic       port_type_sel_lo,
  input wire logic       parallel_style_sel,
  input wire logic       addr_latch_or_top_addr,
  input wire logic       read_strobe_or_serial_clk,
  input wire logic       host_bus_oe,
  input wire logic [7:0] dev_bus_oe,
  input wire logic       int_out,
  input wire logic       int_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  wire ser = port_type_sel_hi && !port_type_sel_lo;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Six cycles cover the pin synchronisers plus the registered outputs
  idle_release_a: assert property (cs_n [*6] |-> dev_bus_oe == 8'h00)
    else $error("bus driven while deselected");
  int_drain_a: assert property (int_oe |-> int_out == 1'b0)
    else $error("interrupt pin driven high");
  test_quiet_a: assert property ((port_type_sel_hi && port_type_sel_lo) [*6]
    |-> !int_oe && dev_bus_oe == 8'h00) else $error("output driven in test mode");
  ser_out_a: assert property ((ser && !cs_n) [*6] |-> dev_bus_oe == 8'h80)
    else $error("serial out not on top bus pin");
  ser_top_a: assert property (ser |-> dev_bus_oe[6:0] == 7'h00)
    else $error("low bus pins driven in serial mode");
  no_fight_a: assert property (!ser && host_bus_oe |-> dev_bus_oe == 8'h00)
    else $error("both ends drive the bus");
  latch_sel_a: assert property ($rose(addr_latch_or_top_addr)
    && !port_type_sel_hi && !port_type_sel_lo |-> !cs_n) else $error("latch while deselected");
  rd_sel_a: assert property ($fell(read_strobe_or_serial_clk)
    && !port_type_sel_hi && !parallel_style_sel |-> !cs_n) else $error("strobe while deselected");
  sclk_sel_a: assert property ($rose(read_strobe_or_serial_clk) && ser |-> !cs_n)
    else $error("serial clock while deselected");
endmodule : qhp_asserts

//--- verification/test_quad_e1_host_port.sv
// Self-checking bench: host end and device end joined over the pin bundle
module test_quad_e1_host_port import qhp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst = 1, req_valid = 0, req_read = 0;
  logic        style = 0, in_edge = 0, out_edge = 0;
  logic        req_ready, rsp_valid, irq, cfg_wr_valid;
  logic [1:0]  req_chan = 0, port_type = 0, cfg_wr_chan, c;
  logic [5:0]  req_addr = 0, cfg_wr_addr, a;
  logic [7:0]  req_wdata = 0, rsp_rdata, cfg_wr_data, d;
  logic [95:0] status_cond = '0;
  logic [15:0] rq[$], wq[$];
  int          num_errors = 0, checked = 0;
  qhp_if bus ();
  always #20 sys_clk = ~sys_clk;
  qhp_dev_end u_qhp_dev_end (.sys_clk, .rst, .port(bus.dev), .status_cond, .cfg_wr_valid,
    .cfg_wr_chan, .cfg_wr_addr, .cfg_wr_data);
  qhp_host_end u_qhp_host_end (.sys_clk, .rst, .port(bus.host), .req_valid, .req_ready,
    .req_read, .req_chan, .req_addr, .req_wdata, .cfg_port_type(port_type), .cfg_style(style),
    .cfg_in_edge(in_edge), .cfg_out_edge(out_edge), .rsp_valid, .rsp_rdata, .irq);
  qhp_asserts chk (.sys_clk, .rst, .cs_n(bus.cs_n), .port_type_sel_hi(bus.port_type_sel_hi),
    .port_type_sel_lo(bus.port_type_sel_lo), .parallel_style_sel(bus.parallel_style_sel),
    .addr_latch_or_top_addr(bus.addr_latch_or_top_addr), .host_bus_oe(bus.host_bus_oe),
    .read_strobe_or_serial_clk(bus.read_strobe_or_serial_clk), .dev_bus_oe(bus.dev_bus_oe),
    .int_out(bus.int_out), .int_oe(bus.int_oe));
  // ********
  // Tasks
  // ********
  task automatic compare(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : compare
  task automatic wait_ready();
    for (int i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge sys_clk);
  endtask : wait_ready
  // One cycle of idle before the take so the host latches the current mode
  task automatic acc(input logic rd, input logic [1:0] ch, input logic [5:0] ad,
                     input logic [7:0] dt);
    wait_ready();
    @(negedge sys_clk);
    {req_valid, req_read, req_chan, req_addr, req_wdata} = {1'b1, rd, ch, ad, dt};
    @(negedge sys_clk);
    req_valid = 1'b0;
    rq.push_back(rd && port_type != 2'b11 ? {8'h00, dt} : 16'h00FF);
    if (!rd && port_type != 2'b11) wq.push_back({ch, ad, dt});
  endtask : acc
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 100 && irq !== lvl; i++) @(negedge sys_clk);
    compare({15'h0000, lvl}, {15'h0000, irq});
  endtask : wait_irq
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ********
  // Result watcher
  // ********
  always @(negedge sys_clk)
  begin
    if (rsp_valid === 1'b1)
      compare(rq.size() ? rq.pop_front() : 16'hXXXX, {8'h00, rsp_rdata});
    if (cfg_wr_valid === 1'b1)
      compare(wq.size() ? wq.pop_front() : 16'hXXXX, {cfg_wr_chan, cfg_wr_addr, cfg_wr_data});
  end
  // ********
  // Sequence
  // ********
  initial
  begin
    void'($urandom(72));
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    wait_irq(1'b0);
    status_cond[8] = 1'b1;
    acc(1'b0, 2'd0, QHP_ADDR_MSK2, 8'h01);
    wait_irq(1'b1);
    acc(1'b0, 2'd0, QHP_ADDR_MSK2, 8'h00);
    wait_irq(1'b0);
    // Status byte keeps the change until a one is written back
    acc(1'b1, 2'd0, QHP_ADDR_SR2, 8'h01);
    acc(1'b0, 2'd0, QHP_ADDR_SR2, 8'h01);
    acc(1'b1, 2'd0, QHP_ADDR_SR2, 8'h00);
    $display("interrupt test done");
    for (int m = 0; m < 8; m++)
    begin
      // Settings may change only once the previous access has finished
      wait_ready();
      port_type = m < 4 ? {1'b0, m[0]} : 2'b10;
      {style, in_edge, out_edge} = {m[1], m[0], m[1]};
      c = 2'($urandom);
      a = 6'($urandom);
      d = 8'($urandom);
      if (m > 3) a[5] = 1'b0;
      // Keep clear of sticky status places and of the test-mode probe address
      if (a[4:2] == 3'b010 || a[4:0] == 5'h1C) a[4:0] = 5'h05;
      acc(1'b0, c, a, d);
      acc(1'b0, c ^ 2'd1, a, ~d);
      acc(1'b1, c, a, d);
      acc(1'b1, c ^ 2'd1, a, ~d);
      $display("mode %0d test done", m);
    end
    wait_ready();
    port_type = 2'b11;
    acc(1'b0, 2'd3, 6'h08, 8'h5A);
    acc(1'b1, 2'd3, 6'h08, 8'h00);
    wait_ready();
    port_type = 2'b01;
    acc(1'b1, 2'd3, 6'h08, 8'h00);
    wait_ready();
    compare(16'h0000, 16'(rq.size() + wq.size()));
    $display("test mode test done");
    print_verdict();
  end
  // Whole run needs about 5500 cycles; allow 25000
  initial
  begin
    #1000000;
    num_errors++;
    print_verdict();
  end
endmodule : test_quad_e1_host_port
